// file: logic/clk_ctrl_pkg.sv
// shared constants for the channel 7 output divider and single-ended divider control
package clk_ctrl_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CH7_DIV_INDEX = 8'h2c;
  localparam logic [7:0] SE_CTRL_INDEX = 8'h2d;
  localparam logic [7:0] FEED_SEL_INDEX = 8'h2e;
  localparam logic [7:0] STATE_INDEX = 8'h2f;
  localparam logic [9:0] CH7_DIV_ADDR = {CH7_DIV_INDEX, 2'b00};
  localparam logic [9:0] SE_CTRL_ADDR = {SE_CTRL_INDEX, 2'b00};
  localparam logic [9:0] FEED_SEL_ADDR = {FEED_SEL_INDEX, 2'b00};
  localparam logic [9:0] STATE_ADDR = {STATE_INDEX, 2'b00};

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CH7_DIV_RESET = 8'h05;
  localparam logic [7:0] SE_CTRL_RESET = 8'h0a;
  localparam logic [1:0] FEED_SEL_RESET = 2'h0;

  // ----------------------------------------------------------------
  // field positions in cmos_divider_and_pin_select
  // ----------------------------------------------------------------
  localparam int SECOND_PRESCALE_LSB = 6;
  localparam int FIRST_PRESCALE_LSB = 4;
  localparam int PIN_B_SOURCE_LSB = 2;
  localparam int PIN_A_SOURCE_LSB = 0;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PRESCALE_OFF = 2'h0;
  localparam logic [1:0] PRESCALE_BY4 = 2'h1;
  localparam logic [1:0] PRESCALE_BY5 = 2'h2;
  localparam logic [7:0] PRESCALE_LIMIT4 = 8'h03;
  localparam logic [7:0] PRESCALE_LIMIT5 = 8'h04;
  localparam logic [1:0] PIN_FROM_DIV_A = 2'h0;
  localparam logic [1:0] PIN_FROM_DIV_B = 2'h1;
  localparam logic [1:0] PIN_STATUS = 2'h2;
  localparam logic [1:0] SRC_FIRST_SYNTH = 2'h0;
  localparam logic [1:0] SRC_SECOND_SYNTH = 2'h1;
  localparam logic [1:0] SRC_PRIMARY_REF = 2'h2;
  localparam logic [7:0] SE_MIN_LIMIT = 8'h05;

endpackage

// file: logic/tick_divider.sv
// divides a one-cycle tick stream by a programmable ratio
`timescale 1ns/1ns
module tick_divider #(
  parameter int WIDTH = 8
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_reset, // async reset, active high
  input wire logic i_enable, // low holds the divider cleared
  input wire logic i_tick, // one source edge
  input wire logic [WIDTH-1:0] i_limit, // ratio minus one
  output logic o_tick, // one divided edge
  output logic o_level // divided clock level
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic wrap;
  logic [WIDTH-1:0] half;

  // count wraps at the limit; high for the first half of each period
  assign wrap = (count_r >= i_limit);
  assign count_nxt = wrap ? '0 : count_r + 1'b1;
  assign half = WIDTH'(({1'b0, i_limit} + 1'b1) >> 1);

  // ----------------------------------------------------------------
  // counter; a lowered limit wraps at once so the output never stalls
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      count_r <= '0;
      o_tick <= 1'b0;
      o_level <= 1'b0;
    end
    else if (!i_enable)
    begin
      count_r <= '0;
      o_tick <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      o_tick <= i_tick && (count_r == '0);
      if (i_tick)
      begin
        count_r <= count_nxt;
        o_level <= (count_nxt < half) || (i_limit == '0 && !o_level);
      end
    end
  end

endmodule // tick_divider

// file: logic/clk_ctrl.sv
// channel 7 output divider and single-ended divider / monitor pin control with apb registers
`timescale 1ns/1ns
module clk_ctrl (
  input wire logic i_sys_clk, // 250 mhz system clock
  input wire logic i_reset, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high = write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic i_nv_load, // pulse: reload settings from nonvolatile image
  input wire logic [7:0] i_nv_ch7_div, // nonvolatile channel 7 setting
  input wire logic [7:0] i_nv_se_ctrl, // nonvolatile single-ended control byte
  input wire logic [1:0] i_ch7_source, // channel 7 source select from its own register
  input wire logic i_first_synth_tick, // edge of first_synthesizer clock
  input wire logic i_second_synth_tick, // edge of second_synthesizer clock
  input wire logic i_primary_ref_tick, // edge of primary reference
  input wire logic i_secondary_ref_tick, // edge of secondary reference
  input wire logic [7:0] i_se_div_a_ratio, // single_ended_divider_a ratio, 0 = off
  input wire logic [7:0] i_se_div_b_ratio, // single_ended_divider_b ratio, 0 = off
  input wire logic i_status_a, // normal status signal for monitor_pin_a
  input wire logic i_status_b, // normal status signal for monitor_pin_b
  output logic o_ch7_tick, // channel 7 output edge
  output logic o_ch7_level, // channel 7 output clock level
  output logic o_monitor_pin_a, // monitor_pin_a output value
  output logic o_monitor_pin_a_oe, // monitor_pin_a driven
  output logic o_monitor_pin_b, // monitor_pin_b output value
  output logic o_monitor_pin_b_oe // monitor_pin_b driven
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] channel7_output_divide_ratio_r;
  logic [7:0] cmos_divider_and_pin_select_r;
  logic [1:0] feed_select_r;
  logic [1:0] second_synth_single_ended_prescale;
  logic [1:0] first_synth_single_ended_prescale;
  logic [1:0] monitor_pin_b_source;
  logic [1:0] monitor_pin_a_source;

  assign second_synth_single_ended_prescale = cmos_divider_and_pin_select_r[clk_ctrl_pkg::SECOND_PRESCALE_LSB +: 2];
  assign first_synth_single_ended_prescale = cmos_divider_and_pin_select_r[clk_ctrl_pkg::FIRST_PRESCALE_LSB +: 2];
  assign monitor_pin_b_source = cmos_divider_and_pin_select_r[clk_ctrl_pkg::PIN_B_SOURCE_LSB +: 2];
  assign monitor_pin_a_source = cmos_divider_and_pin_select_r[clk_ctrl_pkg::PIN_A_SOURCE_LSB +: 2];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_phase;
  logic access_done;
  logic hit_ch7;
  logic hit_se;
  logic hit_feed;
  logic hit_state;
  logic mapped;
  logic wr_ch7;
  logic wr_se;
  logic wr_feed;
  logic [7:0] state_word;
  logic [31:0] read_mux;

  // answer is prepared in the setup cycle so the access cycle never waits
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign hit_ch7 = (paddr[9:0] == clk_ctrl_pkg::CH7_DIV_ADDR) && (paddr[11:10] == 2'h0);
  assign hit_se = (paddr[9:0] == clk_ctrl_pkg::SE_CTRL_ADDR) && (paddr[11:10] == 2'h0);
  assign hit_feed = (paddr[9:0] == clk_ctrl_pkg::FEED_SEL_ADDR) && (paddr[11:10] == 2'h0);
  assign hit_state = (paddr[9:0] == clk_ctrl_pkg::STATE_ADDR) && (paddr[11:10] == 2'h0);
  assign mapped = hit_ch7 || hit_se || hit_feed || hit_state;
  // only byte lane 0 carries data; a write without it leaves the register alone
  assign wr_ch7 = access_done && pwrite && hit_ch7 && pstrb[0];
  assign wr_se = access_done && pwrite && hit_se && pstrb[0];
  assign wr_feed = access_done && pwrite && hit_feed && pstrb[0];

  // read mux; the state register is read-only and ignores writes
  assign read_mux = hit_ch7 ? {24'h000000, channel7_output_divide_ratio_r} :
                    hit_se ? {24'h000000, cmos_divider_and_pin_select_r} :
                    hit_feed ? {30'h0, feed_select_r} :
                    hit_state ? {24'h000000, state_word} : 32'h00000000;

  // ----------------------------------------------------------------
  // apb answer flops
  // ----------------------------------------------------------------
  // ready follows every setup cycle by exactly one clock: zero wait states, no stall path
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup_phase;
      pslverr <= setup_phase && !mapped;
      prdata <= (setup_phase && !pwrite) ? read_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // settings; software write wins over a nonvolatile reload in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      channel7_output_divide_ratio_r <= clk_ctrl_pkg::CH7_DIV_RESET;
      cmos_divider_and_pin_select_r <= clk_ctrl_pkg::SE_CTRL_RESET;
      feed_select_r <= clk_ctrl_pkg::FEED_SEL_RESET;
    end
    else
    begin
      if (wr_ch7)
        channel7_output_divide_ratio_r <= pwdata[7:0];
      else if (i_nv_load)
        channel7_output_divide_ratio_r <= i_nv_ch7_div;
      if (wr_se)
        cmos_divider_and_pin_select_r <= pwdata[7:0];
      else if (i_nv_load)
        cmos_divider_and_pin_select_r <= i_nv_se_ctrl;
      if (wr_feed)
        feed_select_r <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // channel 7 divider
  // ----------------------------------------------------------------
  logic ch7_from_synth;
  logic ch7_src_tick;
  logic ch7_ref_tick;
  logic ch7_div_tick;
  logic ch7_div_level;

  // reference sources bypass the divider entirely
  assign ch7_from_synth = (i_ch7_source == clk_ctrl_pkg::SRC_FIRST_SYNTH) ||
                          (i_ch7_source == clk_ctrl_pkg::SRC_SECOND_SYNTH);
  assign ch7_src_tick = (i_ch7_source == clk_ctrl_pkg::SRC_FIRST_SYNTH) ? i_first_synth_tick : i_second_synth_tick;
  assign ch7_ref_tick = (i_ch7_source == clk_ctrl_pkg::SRC_PRIMARY_REF) ? i_primary_ref_tick : i_secondary_ref_tick;

  // held cleared while a reference is selected, so a synthesizer source restarts in phase
  tick_divider #(
    .WIDTH(8)
  ) ch7_divider (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_enable(ch7_from_synth),
    .i_tick(ch7_src_tick),
    .i_limit(channel7_output_divide_ratio_r),
    .o_tick(ch7_div_tick),
    .o_level(ch7_div_level)
  );

  // undivided reference level follows each reference edge as a toggle
  logic ref_level_r;

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      ref_level_r <= 1'b0;
    else if (!ch7_from_synth && ch7_ref_tick)
      ref_level_r <= !ref_level_r;
  end

  // channel 7 outputs registered; one cycle behind the divider, or behind the reference tick and level flop
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_ch7_tick <= 1'b0;
      o_ch7_level <= 1'b0;
    end
    else
    begin
      o_ch7_tick <= ch7_from_synth ? ch7_div_tick : ch7_ref_tick;
      o_ch7_level <= ch7_from_synth ? ch7_div_level : ref_level_r;
    end
  end

  // ----------------------------------------------------------------
  // synthesizer prescales and single-ended dividers (generate per path)
  // ----------------------------------------------------------------
  logic [1:0] prescale_code [2];
  logic [1:0] synth_tick;
  logic [1:0] prescale_on;
  logic [1:0] prescale_tick;
  logic [1:0] feed_tick;
  logic [1:0] se_on;
  logic [1:0] se_level;
  logic [7:0] se_ratio [2];
  logic [7:0] se_limit [2];
  logic [7:0] prescale_limit [2];

  assign prescale_code[0] = first_synth_single_ended_prescale;
  assign prescale_code[1] = second_synth_single_ended_prescale;
  assign synth_tick = {i_second_synth_tick, i_first_synth_tick};
  assign se_ratio[0] = i_se_div_a_ratio;
  assign se_ratio[1] = i_se_div_b_ratio;

  // index 0 is the first synthesizer path and divider a, index 1 the second and divider b
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_path
      // reserved code falls through to off, keeping the divider starved
      assign prescale_on[g] = (prescale_code[g] == clk_ctrl_pkg::PRESCALE_BY4) ||
                              (prescale_code[g] == clk_ctrl_pkg::PRESCALE_BY5);
      assign prescale_limit[g] = (prescale_code[g] == clk_ctrl_pkg::PRESCALE_BY5) ?
                                 clk_ctrl_pkg::PRESCALE_LIMIT5 : clk_ctrl_pkg::PRESCALE_LIMIT4;

      tick_divider #(
        .WIDTH(8)
      ) prescaler (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_enable(prescale_on[g]),
        .i_tick(synth_tick[g]),
        .i_limit(prescale_limit[g]),
        .o_tick(prescale_tick[g]),
        .o_level()
      );

      // divider a takes its native feed (first) unless crossed, b likewise
      assign feed_tick[g] = feed_select_r[g] ? prescale_tick[1 - g] : prescale_tick[g];
      // ratios below six run at six; zero stops the divider
      assign se_on[g] = (se_ratio[g] != 8'h00);
      assign se_limit[g] = (se_ratio[g] <= clk_ctrl_pkg::SE_MIN_LIMIT) ? clk_ctrl_pkg::SE_MIN_LIMIT :
                           se_ratio[g] - 8'h01;

      tick_divider #(
        .WIDTH(8)
      ) se_divider (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_enable(se_on[g]),
        .i_tick(feed_tick[g]),
        .i_limit(se_limit[g]),
        .o_tick(),
        .o_level(se_level[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // monitor pin selection
  // ----------------------------------------------------------------
  logic pin_a_val;
  logic pin_b_val;
  logic pin_a_en;
  logic pin_b_en;

  // disabled code releases the pin and parks the data low
  assign pin_a_val = (monitor_pin_a_source == clk_ctrl_pkg::PIN_FROM_DIV_A) ? se_level[0] :
                     (monitor_pin_a_source == clk_ctrl_pkg::PIN_FROM_DIV_B) ? se_level[1] :
                     (monitor_pin_a_source == clk_ctrl_pkg::PIN_STATUS) ? i_status_a : 1'b0;
  assign pin_b_val = (monitor_pin_b_source == clk_ctrl_pkg::PIN_FROM_DIV_A) ? se_level[0] :
                     (monitor_pin_b_source == clk_ctrl_pkg::PIN_FROM_DIV_B) ? se_level[1] :
                     (monitor_pin_b_source == clk_ctrl_pkg::PIN_STATUS) ? i_status_b : 1'b0;
  assign pin_a_en = (monitor_pin_a_source != 2'h3);
  assign pin_b_en = (monitor_pin_b_source != 2'h3);

  // pins registered so the pads never see decode glitches when the select changes
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_monitor_pin_a <= 1'b0;
      o_monitor_pin_a_oe <= 1'b0;
      o_monitor_pin_b <= 1'b0;
      o_monitor_pin_b_oe <= 1'b0;
    end
    else
    begin
      o_monitor_pin_a <= pin_a_val;
      o_monitor_pin_a_oe <= pin_a_en;
      o_monitor_pin_b <= pin_b_val;
      o_monitor_pin_b_oe <= pin_b_en;
    end
  end

  // ----------------------------------------------------------------
  // read-only state word for software
  // ----------------------------------------------------------------
  assign state_word = {2'h0, se_level, se_on, prescale_on};

endmodule // clk_ctrl

// file: bench/clk_ctrl_props.sv
// concurrent checks on the clock control block ports
`timescale 1ns/1ns
module clk_ctrl_props (
  input wire logic i_sys_clk, // clock
  input wire logic i_reset, // async reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [3:0] pstrb, // strobes
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic i_nv_load, // reload
  input wire logic [7:0] i_nv_ch7_div, // stored ratio
  input wire logic [7:0] i_nv_se_ctrl, // stored control
  input wire logic [1:0] i_ch7_source, // ch7 source
  input wire logic i_primary_ref_tick, // ref edge
  input wire logic i_secondary_ref_tick, // ref edge
  input wire logic i_status_b, // status b
  input wire logic o_ch7_tick, // ch7 edge
  input wire logic o_monitor_pin_a, // pin a
  input wire logic o_monitor_pin_a_oe, // pin a drive
  input wire logic o_monitor_pin_b, // pin b
  input wire logic o_monitor_pin_b_oe // pin b drive
);
  localparam logic [11:0] CH7_A = {2'b00, clk_ctrl_pkg::CH7_DIV_ADDR};
  localparam logic [11:0] SE_A = {2'b00, clk_ctrl_pkg::SE_CTRL_ADDR};
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // -----------------------------------------------
  // shadow settings, a software write beats a reload
  // -----------------------------------------------
  logic [7:0] ch7_r, ch7_nxt, se_r, se_nxt;
  logic wr_go, ref_sel;
  logic [1:0] pin_a_code, pin_b_code;
  assign wr_go = psel && penable && pready && pwrite && pstrb[0];
  assign ch7_nxt = (wr_go && paddr == CH7_A) ? pwdata[7:0] : (i_nv_load ? i_nv_ch7_div : ch7_r);
  assign se_nxt = (wr_go && paddr == SE_A) ? pwdata[7:0] : (i_nv_load ? i_nv_se_ctrl : se_r);
  assign ref_sel = i_ch7_source[0] ? i_secondary_ref_tick : i_primary_ref_tick;
  assign pin_a_code = se_r[1:0];
  assign pin_b_code = se_r[3:2];
  // shadows reset to the documented defaults
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ch7_r <= 8'h05;
      se_r <= 8'h0a;
    end
    else
    begin
      ch7_r <= ch7_nxt;
      se_r <= se_nxt;
    end
  end
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  a_unmapped_err: assert property (psel && !penable && paddr[11:10] != 2'b00 |=> pready && pslverr)
    else $error("no error on unmapped address");
  a_ch7_readback: assert property (pready && !pwrite && paddr == CH7_A |-> prdata == {24'h0, $past(ch7_r)})
    else $error("ch7 ratio read back wrong");
  a_ref_bypass: assert property (i_ch7_source[1] && $stable(i_ch7_source) |=> o_ch7_tick == $past(ref_sel))
    else $error("reference not passed undivided");
  a_pin_a_off: assert property (pin_a_code == 2'h3 && $past(pin_a_code) == 2'h3 && !$past(i_reset)
    |-> !o_monitor_pin_a_oe && !o_monitor_pin_a) else $error("disabled pin a still driven");
  a_pin_b_status: assert property (pin_b_code == 2'h2 && $past(pin_b_code) == 2'h2 && !$past(i_reset)
    |-> o_monitor_pin_b_oe && o_monitor_pin_b == $past(i_status_b)) else $error("pin b not showing status");
  a_oe_after_reset: assert property ($fell(i_reset) |=> o_monitor_pin_a_oe && o_monitor_pin_b_oe)
    else $error("pins not driven after reset");
  c_unmapped: cover property (pready && pslverr);
  c_ch7_read: cover property (pready && !pwrite && paddr == CH7_A);
  c_pin_clock: cover property (o_monitor_pin_a_oe && $rose(o_monitor_pin_a));
  c_synth_tick: cover property (o_ch7_tick && !i_ch7_source[1]);
endmodule // clk_ctrl_props

bind clk_ctrl clk_ctrl_props u_props (.i_sys_clk, .i_reset, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .i_nv_load, .i_nv_ch7_div, .i_nv_se_ctrl, .i_ch7_source,
  .i_primary_ref_tick, .i_secondary_ref_tick, .i_status_b, .o_ch7_tick, .o_monitor_pin_a,
  .o_monitor_pin_a_oe, .o_monitor_pin_b, .o_monitor_pin_b_oe);

// file: bench/testbench.sv
// self-checking bench for the clock control block
`timescale 1ns/1ns
module testbench;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} reg_row_t;
  typedef struct {logic [1:0] src; logic [7:0] div;} ch7_row_t;
  typedef struct {logic [7:0] se; logic [1:0] feed; int ea; int eb;} pin_row_t;
  logic i_sys_clk = 0, i_reset = 1, psel = 0, penable = 0, pwrite = 0, i_nv_load = 0, i_status_a = 0, i_status_b = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rv, prdata;
  logic [3:0] ticks = 0;
  logic [7:0] i_nv_ch7_div = 0, i_nv_se_ctrl = 0;
  logic [1:0] i_ch7_source = 0;
  logic re, pready, pslverr, o_ch7_tick, o_ch7_level, o_monitor_pin_a, o_monitor_pin_a_oe;
  logic o_monitor_pin_b, o_monitor_pin_b_oe, pa_q = 0, pb_q = 0, lv_q = 0;
  int n_fail = 0, num_checks = 0, n_tick = 0, n_pa = 0, n_pb = 0, n_lv = 0, s_t, s_a, s_b, s_l, win, cyc = 0;
  // last row: the state word ignores writes; with both prescales off only the divider enables read high
  reg_row_t regs[7] = '{'{12'h0b0, 32'hff, 32'hff, 0}, '{12'h0b0, 32'hffffff00, 32'h0, 0},
    '{12'h0b4, 32'hc3, 32'hc3, 0}, '{12'h0b8, 32'h3, 32'h3, 0}, '{12'h0c0, 32'h5a, 32'h0, 1},
    '{12'h4b0, 32'h11, 32'h0, 1}, '{12'h0bc, 32'hff, 32'h0c, 0}};
  ch7_row_t ch7s[6] = '{'{0, 0}, '{0, 2}, '{1, 5}, '{0, 255}, '{2, 4}, '{3, 4}};
  // divider a is set to 6 and divider b to 7; the window of 840 cycles holds whole periods of all
  pin_row_t pins[6] = '{'{8'h94, 0, 35, 24}, '{8'h91, 0, 24, 35}, '{8'h94, 3, 28, 30},
    '{8'h34, 0, 0, 0}, '{8'he4, 0, 28, 0}, '{8'h5f, 0, 0, 0}};
  clk_ctrl DUT (.i_sys_clk, .i_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
    .pready, .pslverr, .i_nv_load, .i_nv_ch7_div, .i_nv_se_ctrl, .i_ch7_source, .i_first_synth_tick(ticks[0]),
    .i_second_synth_tick(ticks[1]), .i_primary_ref_tick(ticks[2]), .i_secondary_ref_tick(ticks[3]),
    .i_se_div_a_ratio(8'h06), .i_se_div_b_ratio(8'h07), .i_status_a, .i_status_b, .o_ch7_tick, .o_ch7_level,
    .o_monitor_pin_a, .o_monitor_pin_a_oe, .o_monitor_pin_b, .o_monitor_pin_b_oe);
  // ---------------------------------------------
  // clock, edge counters and hang guard
  // ---------------------------------------------
  initial forever #2 i_sys_clk = ~i_sys_clk;
  // counts are read at the falling edge so they never race the increments
  always @(posedge i_sys_clk)
  begin
    n_tick += (o_ch7_tick === 1'b1);
    n_pa += (o_monitor_pin_a === 1'b1 && pa_q === 1'b0);
    n_pb += (o_monitor_pin_b === 1'b1 && pb_q === 1'b0);
    n_lv += (o_ch7_level === 1'b1 && lv_q === 1'b0);
    lv_q = o_ch7_level;
    pa_q = o_monitor_pin_a;
    pb_q = o_monitor_pin_b;
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      final_report();
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask
  // request held from setup until ready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    @(posedge i_sys_clk);
    while (pready !== 1'b1)
      @(posedge i_sys_clk);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read data", exp, rv);
  endtask
  task count(input int n);
    @(negedge i_sys_clk);
    {s_t, s_a, s_b, s_l} = {n_tick, n_pa, n_pb, n_lv};
    repeat (n) @(negedge i_sys_clk);
    {s_t, s_a, s_b, s_l} = {n_tick - s_t, n_pa - s_a, n_pb - s_b, n_lv - s_l};
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    rd_chk(12'h0b0, 32'h05);
    rd_chk(12'h0b4, 32'h0a);
    foreach (regs[i])
    begin
      apb(1'b1, regs[i].a, regs[i].w);
      chk("write error", {31'h0, regs[i].e}, {31'h0, re});
      apb(1'b0, regs[i].a, 32'h0);
      chk("read error", {31'h0, regs[i].e}, {31'h0, re});
      chk("read back", regs[i].r, rv);
    end
    foreach (ch7s[i])
    begin
      apb(1'b1, 12'h0b0, {24'h0, ch7s[i].div});
      i_ch7_source <= ch7s[i].src;
      ticks <= 4'h1 << ch7s[i].src;
      repeat (300) @(posedge i_sys_clk);
      win = 2 * (int'(ch7s[i].div) + 1);
      count(win);
      chk("ch7 edges", ch7s[i].src[1] ? win : 2, s_t);
      // a reference level toggles per tick; setting zero toggles too, else one rise per period
      chk("ch7 level rises", ch7s[i].src[1] ? win / 2 : (ch7s[i].div == 0 ? 1 : 2), s_l);
    end
    @(posedge i_sys_clk);
    ticks <= 4'h3;
    foreach (pins[i])
    begin
      apb(1'b1, 12'h0b8, {30'h0, pins[i].feed});
      apb(1'b1, 12'h0b4, {24'h0, pins[i].se});
      repeat (100) @(posedge i_sys_clk);
      count(840);
      chk("pin a edges", pins[i].ea, s_a);
      chk("pin b edges", pins[i].eb, s_b);
    end
    chk("pin drive", 32'h0, {30'h0, o_monitor_pin_a_oe, o_monitor_pin_b_oe});
    apb(1'b1, 12'h0b4, 32'h0a);
    for (int k = 0; k < 2; k++)
    begin
      i_status_a <= k[0];
      i_status_b <= !k[0];
      repeat (3) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      chk("status pins", {30'h0, k[0], !k[0]}, {30'h0, o_monitor_pin_a, o_monitor_pin_b});
      @(posedge i_sys_clk);
    end
    i_nv_ch7_div <= 8'h07;
    i_nv_se_ctrl <= 8'h0f;
    i_nv_load <= 1'b1;
    @(posedge i_sys_clk);
    i_nv_load <= 1'b0;
    rd_chk(12'h0b0, 32'h07);
    rd_chk(12'h0b4, 32'h0f);
    apb(1'b1, 12'h0b0, 32'h33);
    i_reset <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    rd_chk(12'h0b0, 32'h05);
    final_report();
  end
endmodule // testbench
